// [inc/osc_cfg.svh]
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH

// ****************************************
// register map
// ****************************************
`define OSC_ADDR_W 12
`define OSC_DATA_W 8
`define OSC_CTRL_ADDR 12'hf86
`define OSC_STAT_ADDR 12'hf87
`define OSC_CTRL_RESET 8'ha0
`define OSC_UNLOCK_KEY1 8'he7
`define OSC_UNLOCK_KEY2 8'h18

// ****************************************
// status bit positions
// ****************************************
`define OSC_ST_SOF_PEND 0
`define OSC_ST_WDF_PEND 1
`define OSC_ST_WDT_DEAD 2
`define OSC_ST_FALLBACK 3
`define OSC_ST_LOCK_LO 4
`define OSC_ST_LOCK_HI 5

// ****************************************
// clock select codes
// ****************************************
`define OSC_SEL_IPO_FAST 3'h0
`define OSC_SEL_IPO_SLOW 3'h1
`define OSC_SEL_XTAL 3'h2
`define OSC_SEL_WDT 3'h3
`define OSC_SEL_EXT_PIN 3'h4
`define OSC_SEL_LAST 3'h4

// ****************************************
// failure detector timing
// ****************************************
`define OSC_WDF_SYSCLKS 8004
`define OSC_WDT_NOM_HZ 10000
`define OSC_SOF_LIMIT_HZ 1000

`endif

// [inc/osc_pkg.sv]
`include "osc_cfg.svh"

package osc_pkg;

  // control register layout, msb first
  typedef struct packed {
    logic ipo_en;
    logic xtl_en;
    logic wdt_en;
    logic sysclk_fail_detect_enable;
    logic watchdog_osc_fail_detect_enable;
    logic [2:0] system_clock_source_field;
  } osc_ctrl_t;

  typedef enum logic [1:0] {
    OSC_LOCKED = 2'b00,
    OSC_KEY1_SEEN = 2'b01,
    OSC_UNLOCKED = 2'b10
  } osc_lock_t;

  // oscillator enables handed to the analog side
  typedef struct packed {
    logic ipo_en;
    logic xtl_en;
    logic wdt_en;
  } osc_en_t;

endpackage

// [logic/osc_top.sv]
`timescale 1ns/1ps
`include "osc_cfg.svh"

// Notes on behaviour
// - unlock needs e7 then 18 writes
// - next write loads register and relocks
// - writes without proper unlock are ignored
// - unlock writes may be separated by cycles
// - other register accesses keep unlock pending
// - route one of five sources as clock
// - trimmed oscillator on after reset, software-off
// - enables may be set after select write
// - primary failure raises non-maskable event
// - primary failure falls back to watchdog oscillator
// - no fallback if watchdog selected or off
// - primary failure below about one kilohertz
// - watchdog failure raises event, no switch
// - primary detection needs running watchdog oscillator
// - watchdog failure after 8004 quiet clocks
// - all sources off stops device until reset
// - select codes zero to four, rest reserved

module osc_top
  import osc_pkg::*;
#(
  parameter int WDF_SYSCLKS = `OSC_WDF_SYSCLKS,
  parameter int SOF_WDT_TICKS = `OSC_WDT_NOM_HZ / `OSC_SOF_LIMIT_HZ
) (
  input wire logic I_CORE_CLK, // system clock
  input wire logic I_RST, // sync reset, active high
  input wire logic [`OSC_ADDR_W-1:0] I_ADDR, // register address
  input wire logic [`OSC_DATA_W-1:0] I_WDATA, // write data
  input wire logic I_WE, // write strobe
  input wire logic I_RE, // read strobe
  input wire logic I_WDT_OSC_MON, // watchdog oscillator clock, async
  input wire logic I_PRI_OSC_MON, // selected primary oscillator, async
  input wire logic I_SOF_ACK, // interrupt logic serviced primary event
  input wire logic I_WDF_ACK, // interrupt logic serviced watchdog event
  output logic [`OSC_DATA_W-1:0] O_RDATA, // read data, cycle after read
  output logic [2:0] O_CLK_SEL, // active system clock source
  output osc_en_t O_OSC_EN, // oscillator enables
  output logic O_SOF_PEND, // primary failure pending
  output logic O_WDF_PEND // watchdog failure pending
);

  // ****************************************
  // register bus decode
  // ****************************************
  logic ctrl_hit;
  logic stat_hit;
  logic ctrl_wr;
  logic stat_wr;

  assign ctrl_hit = (I_ADDR == `OSC_CTRL_ADDR);
  assign stat_hit = (I_ADDR == `OSC_STAT_ADDR);
  assign ctrl_wr = I_WE && ctrl_hit;
  assign stat_wr = I_WE && stat_hit;

  // ****************************************
  // unlock sequencer
  // ****************************************
  osc_lock_t lock_q;
  osc_lock_t lock_d;
  logic load_ctrl;

  // only writes to the control address move the sequencer; reads and
  // other addresses pass through without touching it
  always_comb begin
    lock_d = lock_q;
    load_ctrl = 1'b0;
    if (ctrl_wr) begin
      case (lock_q)
        OSC_LOCKED: begin
          if (I_WDATA == `OSC_UNLOCK_KEY1) begin
            lock_d = OSC_KEY1_SEEN;
          end
        end
        OSC_KEY1_SEEN: begin
          if (I_WDATA == `OSC_UNLOCK_KEY2) begin
            lock_d = OSC_UNLOCKED;
          end else if (I_WDATA == `OSC_UNLOCK_KEY1) begin
            lock_d = OSC_KEY1_SEEN;
          end else begin
            lock_d = OSC_LOCKED;
          end
        end
        OSC_UNLOCKED: begin
          load_ctrl = 1'b1;
          lock_d = OSC_LOCKED;
        end
        default: begin
          lock_d = OSC_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      lock_q <= OSC_LOCKED;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ****************************************
  // oscillator monitor synchronisers
  // ****************************************
  logic wdt_s1_q;
  logic wdt_s2_q;
  logic wdt_s3_q;
  logic pri_s1_q;
  logic pri_s2_q;
  logic pri_s3_q;
  logic wdt_edge;
  logic pri_edge;

  // two flops settle the async oscillator lines; the third only keeps the
  // previous settled level for the rising-edge detect
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      wdt_s1_q <= 1'b0;
      wdt_s2_q <= 1'b0;
      wdt_s3_q <= 1'b0;
      pri_s1_q <= 1'b0;
      pri_s2_q <= 1'b0;
      pri_s3_q <= 1'b0;
    end else begin
      wdt_s1_q <= I_WDT_OSC_MON;
      wdt_s2_q <= wdt_s1_q;
      wdt_s3_q <= wdt_s2_q;
      pri_s1_q <= I_PRI_OSC_MON;
      pri_s2_q <= pri_s1_q;
      pri_s3_q <= pri_s2_q;
    end
  end

  assign wdt_edge = wdt_s2_q && !wdt_s3_q;
  assign pri_edge = pri_s2_q && !pri_s3_q;

  // ****************************************
  // control register
  // ****************************************
  osc_ctrl_t ctrl_q;
  osc_ctrl_t wr_val;
  logic sof_fire;
  logic do_fallback;

  assign wr_val = osc_ctrl_t'(I_WDATA);

  // fallback may only happen when the watchdog oscillator is running
  // and is not already the clock source
  assign do_fallback = sof_fire && ctrl_q.wdt_en
    && (ctrl_q.system_clock_source_field != `OSC_SEL_WDT);

  // a write in the fallback cycle still loads its enables and relocks;
  // the later assignment lets the fallback keep the watchdog as source
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl_q <= osc_ctrl_t'(`OSC_CTRL_RESET);
    end else begin
      if (load_ctrl) begin
        ctrl_q.ipo_en <= wr_val.ipo_en;
        ctrl_q.xtl_en <= wr_val.xtl_en;
        ctrl_q.wdt_en <= wr_val.wdt_en;
        ctrl_q.sysclk_fail_detect_enable <= wr_val.sysclk_fail_detect_enable;
        ctrl_q.watchdog_osc_fail_detect_enable <= wr_val.watchdog_osc_fail_detect_enable;
        // reserved codes leave the source as it was to avoid a dead clock
        if (wr_val.system_clock_source_field <= `OSC_SEL_LAST) begin
          ctrl_q.system_clock_source_field <= wr_val.system_clock_source_field;
        end
      end
      if (do_fallback) begin
        ctrl_q.system_clock_source_field <= `OSC_SEL_WDT;
      end
    end
  end

  // ****************************************
  // watchdog oscillator failure detector
  // ****************************************
  localparam int WDF_W = $clog2(WDF_SYSCLKS + 1);
  logic [WDF_W-1:0] wdf_cnt_q;
  logic wdt_dead_q;
  logic wdf_fire;
  logic wdf_armed;

  // the detector cannot work while the watchdog clocks the system or is off
  assign wdf_armed = ctrl_q.watchdog_osc_fail_detect_enable && ctrl_q.wdt_en
    && (ctrl_q.system_clock_source_field != `OSC_SEL_WDT);
  assign wdf_fire = wdf_armed && !wdt_dead_q && !wdt_edge
    && (wdf_cnt_q == WDF_W'(WDF_SYSCLKS - 1));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      wdf_cnt_q <= '0;
    end else if (!wdf_armed || wdt_edge || wdt_dead_q) begin
      wdf_cnt_q <= '0;
    end else begin
      wdf_cnt_q <= wdf_cnt_q + WDF_W'(1);
    end
  end

  // a dead watchdog stays dead until it ticks again or reset
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      wdt_dead_q <= 1'b0;
    end else if (wdf_fire) begin
      wdt_dead_q <= 1'b1;
    end else if (wdt_edge) begin
      wdt_dead_q <= 1'b0;
    end
  end

  // ****************************************
  // primary oscillator failure detector
  // ****************************************
  localparam int SOF_W = $clog2(SOF_WDT_TICKS + 1);
  logic [SOF_W-1:0] sof_cnt_q;
  logic sof_armed;

  // watchdog ticks act as the time base; with a nominal 10 khz watchdog,
  // ten ticks without a primary edge means below about 1 khz
  // the threshold follows the watchdog's low accuracy, so treat it as rough
  assign sof_armed = ctrl_q.sysclk_fail_detect_enable && !wdt_dead_q
    && (ctrl_q.system_clock_source_field != `OSC_SEL_WDT);
  assign sof_fire = sof_armed && wdt_edge && !pri_edge
    && (sof_cnt_q == SOF_W'(SOF_WDT_TICKS - 1));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sof_cnt_q <= '0;
    end else if (!sof_armed || pri_edge || sof_fire) begin
      sof_cnt_q <= '0;
    end else if (wdt_edge) begin
      sof_cnt_q <= sof_cnt_q + SOF_W'(1);
    end
  end

  // ****************************************
  // failure event pending flags
  // ****************************************
  logic sof_pend_q;
  logic wdf_pend_q;
  logic fallback_q;
  logic sof_clr;
  logic wdf_clr;

  // write one to the status register, or the interrupt acknowledge, clears
  // the acknowledges come from interrupt logic on this same clock, so no sync
  assign sof_clr = I_SOF_ACK || (stat_wr && I_WDATA[`OSC_ST_SOF_PEND]);
  assign wdf_clr = I_WDF_ACK || (stat_wr && I_WDATA[`OSC_ST_WDF_PEND]);

  // a new failure in the clear cycle wins so no event is dropped
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sof_pend_q <= 1'b0;
    end else if (sof_fire) begin
      sof_pend_q <= 1'b1;
    end else if (sof_clr) begin
      sof_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      wdf_pend_q <= 1'b0;
    end else if (wdf_fire) begin
      wdf_pend_q <= 1'b1;
    end else if (wdf_clr) begin
      wdf_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      fallback_q <= 1'b0;
    end else if (do_fallback) begin
      fallback_q <= 1'b1;
    end else if (load_ctrl) begin
      fallback_q <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // nothing here keeps a source alive: software may switch every working
  // oscillator off, after which only a power-on reset recovers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_CLK_SEL <= `OSC_SEL_IPO_FAST;
      O_OSC_EN <= '0;
    end else begin
      O_CLK_SEL <= ctrl_q.system_clock_source_field;
      O_OSC_EN.ipo_en <= ctrl_q.ipo_en;
      O_OSC_EN.xtl_en <= ctrl_q.xtl_en;
      O_OSC_EN.wdt_en <= ctrl_q.wdt_en;
    end
  end

  assign O_SOF_PEND = sof_pend_q;
  assign O_WDF_PEND = wdf_pend_q;

  // ****************************************
  // read data
  // ****************************************
  // status: pending flags, watchdog dead, fallback taken and the lock state,
  // so software can see a half-done unlock; idle cycles and unmapped
  // addresses read as zero
  logic [`OSC_DATA_W-1:0] stat_val;

  always_comb begin
    stat_val = '0;
    stat_val[`OSC_ST_SOF_PEND] = sof_pend_q;
    stat_val[`OSC_ST_WDF_PEND] = wdf_pend_q;
    stat_val[`OSC_ST_WDT_DEAD] = wdt_dead_q;
    stat_val[`OSC_ST_FALLBACK] = fallback_q;
    stat_val[`OSC_ST_LOCK_HI:`OSC_ST_LOCK_LO] = lock_q;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_RDATA <= '0;
    end else if (I_RE && ctrl_hit) begin
      O_RDATA <= ctrl_q;
    end else if (I_RE && stat_hit) begin
      O_RDATA <= stat_val;
    end else begin
      O_RDATA <= '0;
    end
  end

endmodule

// [dv/osc_top_asserts.sv]
`timescale 1ns/1ps
`include "osc_cfg.svh"

module osc_top_asserts
  import osc_pkg::*;
#(
  parameter int WDF_SYSCLKS = 20
) (
  input wire logic I_CORE_CLK, // clock
  input wire logic I_RST, // reset
  input wire logic [`OSC_ADDR_W-1:0] I_ADDR, // address
  input wire logic [`OSC_DATA_W-1:0] I_WDATA, // write data
  input wire logic I_WE, // write strobe
  input wire logic I_WDT_OSC_MON, // watchdog clock
  input wire logic I_SOF_ACK, // primary ack
  input wire logic I_WDF_ACK, // watchdog ack
  input wire logic [2:0] O_CLK_SEL, // source
  input wire osc_en_t O_OSC_EN, // enables
  input wire logic O_SOF_PEND, // primary pending
  input wire logic O_WDF_PEND // watchdog pending
);
  // ****************************************
  // reference lock tracking
  // ****************************************
  logic [1:0] lk_q;
  logic [7:0] wr_q;
  logic wdt_s_q;
  int quiet_q;
  wire ctl_wr = I_WE && I_ADDR == `OSC_CTRL_ADDR;
  wire stat_wr = I_WE && I_ADDR == `OSC_STAT_ADDR;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      lk_q <= 2'h0;
    end else if (ctl_wr) begin
      lk_q <= (lk_q == 2'h2) ? 2'h0 : (I_WDATA == `OSC_UNLOCK_KEY1) ? 2'h1 :
        (lk_q == 2'h1 && I_WDATA == `OSC_UNLOCK_KEY2) ? 2'h2 : 2'h0;
    end
  end
  always_ff @(posedge I_CORE_CLK) begin
    if (ctl_wr && lk_q == 2'h2) begin
      wr_q <= I_WDATA;
    end
  end
  // raw edges lead the synced ones, so this count never undershoots
  always_ff @(posedge I_CORE_CLK) begin
    wdt_s_q <= I_WDT_OSC_MON;
    if (I_RST || (I_WDT_OSC_MON && !wdt_s_q)) begin
      quiet_q <= 0;
    end else if (quiet_q < 100000) begin
      quiet_q <= quiet_q + 1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  sel_range_a: assert property (O_CLK_SEL <= `OSC_SEL_LAST)
    else $error("select code out of range");
  lock_ignore_a: assert property (ctl_wr && lk_q != 2'h2 |-> ##2 $stable(O_CLK_SEL) && $stable(O_OSC_EN)
    ##1 $stable(O_CLK_SEL) && $stable(O_OSC_EN)) else $error("locked write changed control");
  ctl_load_a: assert property (ctl_wr && lk_q == 2'h2 && I_WDATA[2:0] <= `OSC_SEL_LAST
    |-> ##2 O_CLK_SEL == wr_q[2:0] && O_OSC_EN == wr_q[7:5]) else $error("unlocked write not loaded");
  rst_val_a: assert property ($fell(I_RST) |-> ##1 O_OSC_EN == 3'h5 && O_CLK_SEL == 3'h0)
    else $error("wrong values after reset");
  ipo_off_a: assert property ($fell(O_OSC_EN.ipo_en) |-> $past(ctl_wr, 2) && $past(lk_q, 2) == 2'h2)
    else $error("oscillator turned off without a write");
  fallback_a: assert property ($rose(O_SOF_PEND) && O_OSC_EN.wdt_en |-> ##[0:2] O_CLK_SEL == `OSC_SEL_WDT)
    else $error("no fallback to watchdog clock");
  wdf_noswitch_a: assert property ($rose(O_WDF_PEND) && !O_SOF_PEND |-> ##1 $stable(O_CLK_SEL)
    ##1 $stable(O_CLK_SEL)) else $error("watchdog failure switched clock");
  sof_hold_a: assert property (O_SOF_PEND && !I_SOF_ACK && !stat_wr |=> O_SOF_PEND)
    else $error("primary event lost");
  wdf_hold_a: assert property (O_WDF_PEND && !I_WDF_ACK && !stat_wr |=> O_WDF_PEND)
    else $error("watchdog event lost");
  wdf_time_a: assert property ($rose(O_WDF_PEND) |-> quiet_q >= WDF_SYSCLKS)
    else $error("watchdog failure declared early");
endmodule

bind osc_top osc_top_asserts #(.WDF_SYSCLKS(WDF_SYSCLKS)) osc_top_asserts_i (.I_CORE_CLK(I_CORE_CLK),
  .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WE(I_WE), .I_WDT_OSC_MON(I_WDT_OSC_MON),
  .I_SOF_ACK(I_SOF_ACK), .I_WDF_ACK(I_WDF_ACK), .O_CLK_SEL(O_CLK_SEL), .O_OSC_EN(O_OSC_EN),
  .O_SOF_PEND(O_SOF_PEND), .O_WDF_PEND(O_WDF_PEND));

// [dv/osc_src_model.sv]
`timescale 1ns/1ps

module osc_src_model
  import osc_pkg::*;
(
  input wire logic i_clk, // core clock
  input wire osc_en_t i_en, // enables
  input wire logic i_wdt_fail, // stop watchdog
  input wire logic i_pri_fail, // stop primary
  input wire logic i_ack_en, // service events
  input wire logic i_sof_pend, // primary pending
  input wire logic i_wdf_pend, // watchdog pending
  output logic o_wdt, // watchdog clock
  output logic o_pri, // primary clock
  output logic o_sof_ack, // primary serviced
  output logic o_wdf_ack // watchdog serviced
);
  logic [1:0] div_q = 2'h0;
  initial o_wdt = 1'b0;
  initial o_pri = 1'b0;
  initial o_sof_ack = 1'b0;
  initial o_wdf_ack = 1'b0;
  // ****************************************
  // sources and interrupt side
  // ****************************************
  // a disabled watchdog oscillator stands still, as the real one does
  always @(posedge i_clk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3 && i_en.wdt_en && !i_wdt_fail) o_wdt <= !o_wdt;
    if (!i_pri_fail) o_pri <= !o_pri;
    o_sof_ack <= i_ack_en && i_sof_pend && !o_sof_ack;
    o_wdf_ack <= i_ack_en && i_wdf_pend && !o_wdf_ack;
  end
endmodule

// [dv/osc_top_tb.sv]
`timescale 1ns/1ps
`include "osc_cfg.svh"

module osc_top_tb
  import osc_pkg::*;
;
  localparam int WDF = 20;
  logic clk, rst, we, re, wdt, pri, sack, wack, sp, wp, wfail, pfail, acken;
  logic [11:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [2:0] sel;
  osc_en_t en;
  int error_cnt = 0;
  int tests_run = 0;
  osc_top #(.WDF_SYSCLKS(WDF), .SOF_WDT_TICKS(3)) osc_top_i (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WE(we), .I_RE(re), .I_WDT_OSC_MON(wdt), .I_PRI_OSC_MON(pri), .I_SOF_ACK(sack),
    .I_WDF_ACK(wack), .O_RDATA(rdata), .O_CLK_SEL(sel), .O_OSC_EN(en), .O_SOF_PEND(sp), .O_WDF_PEND(wp));
  osc_src_model osc_src_model_i (.i_clk(clk), .i_en(en), .i_wdt_fail(wfail), .i_pri_fail(pfail),
    .i_ack_en(acken), .i_sof_pend(sp), .i_wdf_pend(wp), .o_wdt(wdt), .o_pri(pri), .o_sof_ack(sack),
    .o_wdf_ack(wack));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wctl(input logic [7:0] v);
    wr(`OSC_CTRL_ADDR, `OSC_UNLOCK_KEY1);
    wr(`OSC_CTRL_ADDR, `OSC_UNLOCK_KEY2);
    wr(`OSC_CTRL_ADDR, v);
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done();
    $display("tests run %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_unlock();
    rd(12'h000);
    chk(d, 8'h00);
    chk({5'h0, en}, 8'h05);
    wr(`OSC_CTRL_ADDR, 8'h18);
    wr(`OSC_CTRL_ADDR, 8'he7);
    rd(`OSC_STAT_ADDR);
    chk(d, 8'h10);
    wr(12'h010, 8'h55);
    wr(`OSC_CTRL_ADDR, 8'h18);
    rd(`OSC_STAT_ADDR);
    chk(d, 8'h20);
    wr(`OSC_CTRL_ADDR, 8'ha1);
    wr(`OSC_CTRL_ADDR, 8'ha2);
    repeat (3) @(posedge clk);
    chk({5'h0, sel}, 8'h01);
    wr(`OSC_CTRL_ADDR, 8'he7);
    wr(`OSC_CTRL_ADDR, 8'h55);
    wr(`OSC_CTRL_ADDR, 8'h18);
    wr(`OSC_CTRL_ADDR, 8'ha2);
    repeat (3) @(posedge clk);
    chk({5'h0, sel}, 8'h01);
  endtask
  task automatic t_codes();
    wctl(8'he0);
    repeat (50) @(posedge clk);
    for (int c = 0; c < 8; c++) begin
      wctl(8'he0 | 8'(c));
      chk({5'h0, sel}, (c > 4) ? 8'h04 : 8'(c));
      chk({5'h0, en}, 8'h07);
    end
    wctl(8'h62);
    chk({5'h0, en}, 8'h03);
    chk({5'h0, sel}, 8'h02);
  endtask
  task automatic t_wdf();
    wctl(8'ha8);
    wfail <= 1'b1;
    repeat (WDF - 10) @(posedge clk);
    chk({7'h0, wp}, 8'h00);
    for (int i = 0; i < 40 && wp !== 1'b1; i++) @(posedge clk);
    chk({5'h0, sel}, 8'h00);
    rd(`OSC_STAT_ADDR);
    chk(d, 8'h06);
    // primary detect enable on while the dead watchdog stops it working
    wctl(8'hb0);
    pfail <= 1'b1;
    repeat (100) @(posedge clk);
    chk({7'h0, sp}, 8'h00);
    acken <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, wp}, 8'h00);
    acken <= 1'b0;
    pfail <= 1'b0;
    wfail <= 1'b0;
  endtask
  task automatic t_sof();
    repeat (20) @(posedge clk);
    pfail <= 1'b1;
    repeat (8) @(posedge clk);
    chk({7'h0, sp}, 8'h00);
    for (int i = 0; i < 200 && sp !== 1'b1; i++) @(posedge clk);
    chk({7'h0, sp}, 8'h01);
    repeat (3) @(posedge clk);
    chk({5'h0, sel}, 8'h03);
    rd(`OSC_STAT_ADDR);
    chk(d, 8'h09);
    wr(`OSC_STAT_ADDR, 8'h02);
    repeat (2) @(posedge clk);
    chk({7'h0, sp}, 8'h01);
    wr(`OSC_STAT_ADDR, 8'h01);
    repeat (100) @(posedge clk);
    chk({7'h0, sp}, 8'h00);
    pfail <= 1'b0;
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, we, re, wfail, pfail, acken} = 6'h20;
    addr = 12'h000;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_unlock();
    t_codes();
    t_wdf();
    t_sof();
    test_done();
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule
